// ---- logic/pwm_one_shot_timer.v ----
// Purpose: one 16-bit pwm / one-shot timer channel with trigger selector
// Assumes: one clock sys_clk at 125 MHz, async active-low reset, plain ports
// Notes:   software settings arrive as ports; four soft trigger bits shared
`include "pwm_timer_consts.vh"

module pwm_one_shot_timer #(
  parameter CNT_WIDTH = 16
) (
  input  wire                 sys_clk,
  input  wire                 resetn,
  input  wire                 ce,
  // buffered cycle and duty values with their write strobes
  input  wire [CNT_WIDTH-1:0] cycle_setting,
  input  wire                 cycle_write,
  input  wire [CNT_WIDTH-1:0] duty_setting,
  input  wire                 duty_write,
  // trigger selection and the shared sources
  input  wire [3:0]           trigger_source_selector,
  input  wire [3:0]           software_trigger_bits,
  input  wire [1:0]           reload_timer_out,
  input  wire [3:0]           external_trigger_pins,
  // channel controls, all plain levels
  input  wire                 timer_run_enable,
  input  wire                 operation_mode_select,
  input  wire                 restart_enable,
  input  wire [1:0]           count_clock_select,
  input  wire                 output_mask,
  input  wire [1:0]           trigger_edge_select,
  // interrupt controls and clear strobes
  input  wire                 irq_enable,
  input  wire [1:0]           irq_cause_select,
  input  wire                 irq_flag_write0,
  input  wire                 dma_clear,
  // output controls and the general-purpose level
  input  wire                 pulse_pin_enable,
  input  wire                 polarity_select,
  input  wire                 port_data,
  // status and pin
  output reg  [CNT_WIDTH-1:0] timer_value,
  output reg                  running,
  output reg                  irq_flag,
  output wire                 irq,
  output reg                  pulse_pin
);

  // ---------------------------------------------------------------------------
  // pin synchronisers for asynchronous trigger sources
  // ---------------------------------------------------------------------------
  reg  [3:0] ext_meta_q;
  reg  [3:0] ext_sync_q;
  reg  [1:0] rld_meta_q;
  reg  [1:0] rld_sync_q;

  // external pins and reload outputs pass two flops before use
  // only the second stage is read, so a metastable first stage never fans out
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ext_meta_q <= 4'h0;
      ext_sync_q <= 4'h0;
      rld_meta_q <= 2'h0;
      rld_sync_q <= 2'h0;
    end else if (ce) begin
      ext_meta_q <= external_trigger_pins;
      ext_sync_q <= ext_meta_q;
      rld_meta_q <= reload_timer_out;
      rld_sync_q <= rld_meta_q;
    end
  end

  // ---------------------------------------------------------------------------
  // trigger source selection
  // ---------------------------------------------------------------------------
  reg trig_in;

  // soft bit value drives trigger directly
  always @* begin
    case (trigger_source_selector)
      4'h0, 4'h1, 4'h2, 4'h3: trig_in = software_trigger_bits[trigger_source_selector[1:0]];
      `TSRC_RELOAD0:          trig_in = rld_sync_q[0];
      `TSRC_RELOAD1:          trig_in = rld_sync_q[1];
      4'h8, 4'h9, 4'ha, 4'hb: trig_in = ext_sync_q[trigger_source_selector[1:0]];
      default:                trig_in = 1'b0; // reserved codes never trigger
    endcase
  end

  // ---------------------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------------------
  reg  trig_prev_q;
  wire trig_rise;
  wire trig_fall;
  reg  trig_event;

  // previous trigger level; resets to the idle low of every source
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trig_prev_q <= 1'b0;
    end else if (ce) begin
      trig_prev_q <= trig_in;
    end
  end

  assign trig_rise = trig_in & ~trig_prev_q;
  assign trig_fall = ~trig_in & trig_prev_q;

  // soft write of 1 seen as rising edge
  // both edges catch every reload toggle
  always @* begin
    case (trigger_edge_select)
      `EDGE_RISE: trig_event = trig_rise;
      `EDGE_FALL: trig_event = trig_fall;
      `EDGE_BOTH: trig_event = trig_rise | trig_fall;
      default:    trig_event = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // count clock
  // ---------------------------------------------------------------------------
  wire tick;

  // select 00 ticks every machine clock
  count_prescaler u_prescaler (
    .sys_clk            (sys_clk),
    .resetn             (resetn),
    .ce                 (ce),
    .count_clock_select (count_clock_select),
    .tick               (tick)
  );

  // ---------------------------------------------------------------------------
  // sequencer strobes, declared early for the buffer logic
  // ---------------------------------------------------------------------------
  // borrow ends a period; load_now ends the wait after a trigger
  wire borrow;
  wire load_now;

  // ---------------------------------------------------------------------------
  // buffered cycle and duty settings
  // ---------------------------------------------------------------------------
  reg [CNT_WIDTH-1:0] cycle_buf_q;
  reg [CNT_WIDTH-1:0] duty_buf_q;
  reg [CNT_WIDTH-1:0] cycle_act_q;
  reg [CNT_WIDTH-1:0] duty_act_q;
  reg                 pend_q;

  // duty write arms the transfer, so cycle must be written first
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cycle_buf_q <= {CNT_WIDTH{1'b1}};
      duty_buf_q  <= {CNT_WIDTH{1'b0}};
      pend_q      <= 1'b0;
    end else if (ce) begin
      if (cycle_write) begin
        cycle_buf_q <= cycle_setting;
      end
      if (duty_write) begin
        duty_buf_q <= duty_setting;
        pend_q     <= 1'b1;
      end else if (load_now | (borrow & ~operation_mode_select)) begin
        // a one-shot borrow moves nothing, so the new values stay pending
        pend_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // channel sequencer
  // ---------------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN  = 2'h2;
  // loading on the second tick stays inside 2.5 count periods
  // even when the trigger lands just after a tick
  localparam [1:0] LOAD_LAST = 2'h1;

  reg [1:0] state_q;
  reg [1:0] wait_q;
  reg       wave_q;
  wire      at_zero;
  wire      duty_match;
  wire      accept;

  assign at_zero    = (timer_value == {CNT_WIDTH{1'b0}});
  assign borrow     = (state_q == ST_RUN) & tick & at_zero & timer_run_enable;
  assign duty_match = (state_q == ST_RUN) & tick & (timer_value == duty_act_q)
                    & timer_run_enable;
  // triggers while running only count with restart on
  // shared source gives all channels the same event
  assign accept     = trig_event & timer_run_enable
                    & ((state_q == ST_IDLE) | ((state_q == ST_RUN) & restart_enable));
  // load on second count tick after trigger, inside 2.5 periods
  assign load_now   = (state_q == ST_WAIT) & tick & (wait_q == LOAD_LAST);

  // state, counter and wave; run enable low overrides every trigger
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= ST_IDLE;
      wait_q      <= 2'h0;
      timer_value <= {CNT_WIDTH{1'b0}};
      wave_q      <= 1'b0;
      cycle_act_q <= {CNT_WIDTH{1'b1}};
      duty_act_q  <= {CNT_WIDTH{1'b0}};
    end else if (ce) begin
      if (!timer_run_enable) begin
        // disabled timer stops and holds low
        state_q <= ST_IDLE;
        wave_q  <= 1'b0;
      end else if (accept) begin
        // restart reloads from the wait stage
        state_q <= ST_WAIT;
        wait_q  <= 2'h0;
      end else begin
        case (state_q)
          ST_WAIT: begin
            if (tick) begin
              wait_q <= wait_q + 2'h1;
            end
            if (load_now) begin
              cycle_act_q <= pend_q ? cycle_buf_q : cycle_act_q;
              duty_act_q  <= pend_q ? duty_buf_q : duty_act_q;
              timer_value <= pend_q ? cycle_buf_q : cycle_act_q;
              wave_q      <= 1'b0;
              state_q     <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (tick) begin
              if (at_zero) begin
                if (operation_mode_select) begin
                  // one-shot ends after the single pulse
                  // stop at end of the pulse
                  state_q <= ST_IDLE;
                  wave_q  <= 1'b0;
                end else begin
                  // continuous pwm reloads and carries on
                  timer_value <= pend_q ? cycle_buf_q : cycle_act_q;
                  cycle_act_q <= pend_q ? cycle_buf_q : cycle_act_q;
                  duty_act_q  <= pend_q ? duty_buf_q : duty_act_q;
                  wave_q      <= 1'b0;
                end
              end else begin
                timer_value <= timer_value - {{(CNT_WIDTH-1){1'b0}}, 1'b1};
                if (timer_value == duty_act_q) begin
                  wave_q <= 1'b1; // high from duty match until borrow
                end
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt flag
  // ---------------------------------------------------------------------------
  reg cause;

  // cause select, borrow on code 01
  always @* begin
    case (irq_cause_select)
      `IRS_TRIGGER: cause = accept;
      `IRS_BORROW:  cause = borrow; // borrow cause
      `IRS_DUTY:    cause = duty_match;
      default:      cause = borrow | duty_match;
    endcase
  end

  // set wins over clear; dma clear also clears
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_flag <= 1'b0;
    end else if (ce) begin
      if (cause & irq_enable) begin
        irq_flag <= 1'b1;
      end else if (irq_flag_write0 | dma_clear) begin
        irq_flag <= 1'b0;
      end
    end
  end

  // request follows the flag only while enabled
  assign irq = irq_flag & irq_enable;

  // ---------------------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------------------
  reg wave_out;

  // mask forces level by polarity bit
  // polarity 0 passes wave as is
  always @* begin
    if (output_mask) begin
      wave_out = polarity_select;
    end else begin
      wave_out = wave_q ^ polarity_select;
    end
  end

  // pin enable selects waveform over port data
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_pin <= 1'b0;
      running   <= 1'b0;
    end else if (ce) begin
      pulse_pin <= pulse_pin_enable ? wave_out : port_data;
      running   <= (state_q != ST_IDLE);
    end
  end

endmodule

// ---- logic/pwm_timer_consts.vh ----
// Purpose: constants shared by the pwm one-shot timer channel
// Assumes: included by its bare name from logic/
// Notes:   codes and reset values as programmed by software through plain ports
`ifndef PWM_TIMER_CONSTS_VH
`define PWM_TIMER_CONSTS_VH

// ---------------------------------------------------------------------------
// timer field widths
// ---------------------------------------------------------------------------
`define CNT_W              16
`define CNT_ONE            16'h0001
`define CNT_ZERO           16'h0000

// ---------------------------------------------------------------------------
// trigger source codes
// ---------------------------------------------------------------------------
`define TSRC_SOFT0         4'h0
`define TSRC_SOFT3         4'h3
`define TSRC_RELOAD0       4'h4
`define TSRC_RELOAD1       4'h5
`define TSRC_EXT0          4'h8
`define TSRC_EXT3          4'hb
`define TSRC_RESET         4'h0

// ---------------------------------------------------------------------------
// edge, clock and cause codes
// ---------------------------------------------------------------------------
`define EDGE_NONE          2'h0
`define EDGE_RISE          2'h1
`define EDGE_FALL          2'h2
`define EDGE_BOTH          2'h3
`define CKSEL_DIV1         2'h0
`define CKSEL_DIV4         2'h1
`define CKSEL_DIV16        2'h2
`define CKSEL_DIV64        2'h3
`define IRS_TRIGGER        2'h0
`define IRS_BORROW         2'h1
`define IRS_DUTY           2'h2
`define IRS_EITHER         2'h3

// ---------------------------------------------------------------------------
// load latency: at most 2.5 count clocks, rounded down to 2 ticks
// ---------------------------------------------------------------------------
`define LOAD_MAX_TENTHS    25
`define LOAD_TICKS         (`LOAD_MAX_TENTHS / 10)

`endif

// ---- logic/count_prescaler.v ----
// Purpose: count clock enable generator for one timer channel
// Assumes: sys_clk domain, ce freezes state
// Notes:   divide 1, 4, 16 or 64 of the machine clock
`include "pwm_timer_consts.vh"

module count_prescaler (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire       ce,
  input  wire [1:0] count_clock_select,
  output reg        tick
);

  reg [5:0] div_q;

  // ---------------------------------------------------------------------------
  // free divider
  // ---------------------------------------------------------------------------
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 6'h00;
    end else if (ce) begin
      div_q <= div_q + 6'h01;
    end
  end

  // tick selection; combinational so div1 is every cycle
  always @* begin
    case (count_clock_select)
      `CKSEL_DIV1:  tick = ce;
      `CKSEL_DIV4:  tick = ce & (div_q[1:0] == 2'h3);
      `CKSEL_DIV16: tick = ce & (div_q[3:0] == 4'hf);
      default:      tick = ce & (div_q == 6'h3f);
    endcase
  end

endmodule

// ---- verif/pwm_timer_sva.sv ----
// Purpose: port checks for the pwm one-shot timer
// Assumes: one clock; timed checks only at the div1 count clock
// Notes:   bound from tb_top
module pwm_timer_sva #(
  parameter CNT_WIDTH = 16
) (
  input wire logic                 sys_clk,
  input wire logic                 resetn,
  input wire logic                 ce,
  input wire logic [3:0]           trigger_source_selector,
  input wire logic [3:0]           software_trigger_bits,
  input wire logic                 timer_run_enable,
  input wire logic                 operation_mode_select,
  input wire logic [1:0]           count_clock_select,
  input wire logic                 output_mask,
  input wire logic [1:0]           trigger_edge_select,
  input wire logic                 irq_enable,
  input wire logic [1:0]           irq_cause_select,
  input wire logic                 irq_flag_write0,
  input wire logic                 dma_clear,
  input wire logic                 pulse_pin_enable,
  input wire logic                 polarity_select,
  input wire logic                 port_data,
  input wire logic [CNT_WIDTH-1:0] timer_value,
  input wire logic                 running,
  input wire logic                 irq_flag,
  input wire logic                 irq,
  input wire logic                 pulse_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic live;
  logic one_q;
  logic last;
  // ----
  // helpers
  // ----
  // counter held 1 on the previous edge, so a 0 now is a borrow tick
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) one_q <= 1'b0;
    else one_q <= (timer_value == CNT_WIDTH'(1));
  end
  // timed checks only hold at the undivided clock
  assign live = ce && timer_run_enable && (count_clock_select == 2'h0);
  assign last = live && running && (timer_value == '0) && one_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----
  // checks
  // ----
  irq_gate_a: assert property (irq == (irq_flag && irq_enable))
    else $error("irq not flag and enable");
  run_gate_a: assert property (!timer_run_enable [*3] |-> !running)
    else $error("running with run enable low");
  pin_port_a: assert property ($past(resetn) && !pulse_pin_enable |=>
    pulse_pin == $past(port_data)) else $error("pin not port data");
  mask_level_a: assert property ($past(resetn) && pulse_pin_enable && output_mask |=>
    pulse_pin == $past(polarity_select)) else $error("masked level wrong");
  borrow_irq_a: assert property (last && irq_enable && irq_cause_select == 2'h1
    |=> irq_flag) else $error("borrow did not set flag");
  flag_clear_a: assert property ((irq_flag_write0 || dma_clear) && !irq_enable
    |=> !irq_flag) else $error("flag not cleared");
  pwm_reload_a: assert property (last && !operation_mode_select
    |=> running && timer_value != '0) else $error("pwm did not reload");
  oneshot_end_a: assert property (last && operation_mode_select |-> ##2 !running)
    else $error("one-shot did not stop");
  load_time_a: assert property ($rose(software_trigger_bits[0]) && live && !running
    && trigger_source_selector == 4'h0 && trigger_edge_select == 2'h1
    |-> ##[2:3] (timer_value != '0)) else $error("counter not loaded in time");
  cover property (last && !operation_mode_select);
  cover property (last && operation_mode_select);
  cover property (irq_flag && dma_clear);
endmodule

// ---- verif/trigger_load_model.sv ----
// Purpose: far side: reload timer and trigger pin source, pulse counter
// Assumes: one clock; go is a one-cycle request
// Notes:   four toggles per request so rise and fall counts stay even
module trigger_load_model #(
  parameter HALF = 40
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic       clr,
  input  wire logic       pulse_pin,
  output logic      [1:0] reload_timer_out,
  output logic      [3:0] external_trigger_pins,
  output logic      [7:0] pulse_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog_q;
  logic pin_q;
  int   gap_q;
  int   left_q;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tog_q <= 1'b0;
      pin_q <= 1'b0;
      gap_q <= 0;
      left_q <= 0;
      pulse_count <= 8'h00;
    end else begin
      pin_q <= pulse_pin;
      if (clr) pulse_count <= 8'h00;
      else if (pulse_pin && !pin_q) pulse_count <= pulse_count + 8'h01;
      if (go) begin
        left_q <= 4;
        gap_q <= HALF;
      end else if (left_q != 0) begin
        gap_q <= (gap_q == 1) ? HALF : gap_q - 1;
        if (gap_q == 1) tog_q <= ~tog_q;
        if (gap_q == 1) left_q <= left_q - 1;
      end
    end
  end
  // unused sources stay low, as idle pins would
  assign reload_timer_out = {1'b0, tog_q};
  assign external_trigger_pins = {3'h0, tog_q};
endmodule

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for the pwm one-shot timer
// Assumes: 125 MHz clock, div1 count clock except one div4 one-shot run
// Notes:   trigger via soft bit 0 or the far-side toggle source
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, resetn = 1'b0, ce = 1'b1, go = 1'b0, clr = 1'b0;
  logic cycle_write = 1'b0, duty_write = 1'b0, timer_run_enable = 1'b1;
  logic operation_mode_select = 1'b0, restart_enable = 1'b0, output_mask = 1'b0;
  logic irq_enable = 1'b1, irq_flag_write0 = 1'b0, dma_clear = 1'b0;
  logic pulse_pin_enable = 1'b1, polarity_select = 1'b0, port_data = 1'b0;
  logic [15:0] cycle_setting = 16'h0003, duty_setting = 16'h0001, timer_value;
  logic [3:0]  trigger_source_selector = 4'h0, software_trigger_bits = 4'h0;
  logic [1:0]  count_clock_select = 2'h0, trigger_edge_select = 2'h1;
  logic [1:0]  irq_cause_select = 2'h1, reload_timer_out;
  logic [3:0]  external_trigger_pins;
  logic [7:0]  pulse_count;
  logic        running, irq_flag, irq, pulse_pin;
  int          err_total = 0, samples_checked = 0, cyc_q = 0;
  logic [3:0]  src_t [8] = '{4'h4, 4'h4, 4'h4, 4'h8, 4'h5, 4'hc, 4'h4, 4'h4};
  logic [2:0]  edg_t [8] = '{3'h7, 3'h3, 3'h5, 3'h7, 3'h7, 3'h7, 3'h1, 3'h6};
  logic [7:0]  exp_t [8] = '{8'h04, 8'h02, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [4:0]  out_t [6] = '{5'h1d, 5'h1a, 5'h15, 5'h12, 5'h03, 5'h0c};
  pwm_one_shot_timer #(.CNT_WIDTH(16)) uut (.sys_clk, .resetn, .ce, .cycle_setting,
    .cycle_write, .duty_setting, .duty_write, .trigger_source_selector,
    .software_trigger_bits, .reload_timer_out, .external_trigger_pins, .timer_run_enable,
    .operation_mode_select, .restart_enable, .count_clock_select, .output_mask,
    .trigger_edge_select, .irq_enable, .irq_cause_select, .irq_flag_write0, .dma_clear,
    .pulse_pin_enable, .polarity_select, .port_data, .timer_value, .running, .irq_flag,
    .irq, .pulse_pin);
  trigger_load_model #(.HALF(40)) far (.sys_clk, .resetn, .go, .clr, .pulse_pin,
    .reload_timer_out, .external_trigger_pins, .pulse_count);
  // clock and hang guard
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_q++;
    if (cyc_q == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic prog(input logic [15:0] c, input logic [15:0] d);
    @(posedge sys_clk);
    cycle_setting <= c;
    cycle_write <= 1'b1;
    @(posedge sys_clk);
    cycle_write <= 1'b0;
    duty_setting <= d;
    duty_write <= 1'b1;
    @(posedge sys_clk);
    duty_write <= 1'b0;
  endtask
  // edge field in bits 2:1, run enable in bit 0
  task automatic mode(input logic m, input logic r, input logic [3:0] s,
                      input logic [2:0] e);
    @(posedge sys_clk);
    operation_mode_select <= m;
    restart_enable <= r;
    trigger_source_selector <= s;
    trigger_edge_select <= e[2:1];
    timer_run_enable <= e[0];
  endtask
  // soft bit rise, returns on the accept edge
  task automatic trig;
    @(posedge sys_clk);
    software_trigger_bits[0] <= 1'b1;
    @(posedge sys_clk);
    software_trigger_bits[0] <= 1'b0;
  endtask
  task automatic clear_count;
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask
  task automatic rise_time(output int n);
    n = 0;
    while (pulse_pin !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    int n;
    tick(3);
    resetn <= 1'b1;
    prog(16'h0003, 16'h0001);
    trig;
    tick(8);
    clear_count;
    tick(40);
    #1 check(pulse_count, 8'h0a);
    check(irq_flag, 1'b1);
    check(irq, 1'b1);
    @(posedge sys_clk);
    timer_run_enable <= 1'b0;
    irq_enable <= 1'b0;
    @(posedge sys_clk);
    irq_flag_write0 <= 1'b1;
    @(posedge sys_clk);
    irq_flag_write0 <= 1'b0;
    #1 check(irq_flag, 1'b0);
    mode(1'b1, 1'b0, 4'h0, 3'h3);
    irq_enable <= 1'b1;
    clear_count;
    trig;
    tick(30);
    #1 check(pulse_count, 8'h01);
    check(running, 1'b0);
    check(irq_flag, 1'b1);
    @(posedge sys_clk);
    irq_enable <= 1'b0;
    dma_clear <= 1'b1;
    @(posedge sys_clk);
    dma_clear <= 1'b0;
    #1 check(irq_flag, 1'b0);
    prog(16'h0014, 16'h000a);
    // a retrigger six edges in either restarts or is ignored
    for (int r = 0; r < 2; r++) begin
      mode(1'b1, r[0], 4'h0, 3'h3);
      trig;
      tick(4);
      trig;
      rise_time(n);
      check(16'(n), r[0] ? 16'h000e : 16'h0008);
      tick(40);
    end
    // divided count clock: still running where div1 would be done
    @(posedge sys_clk);
    count_clock_select <= 2'h1;
    irq_cause_select <= 2'h2;
    irq_enable <= 1'b1;
    mode(1'b1, 1'b0, 4'h0, 3'h3);
    clear_count;
    trig;
    tick(40);
    #1 check(running, 1'b1);
    tick(80);
    #1 check(pulse_count, 8'h01);
    check(irq_flag, 1'b1);
    check(running, 1'b0);
    @(posedge sys_clk);
    count_clock_select <= 2'h0;
    for (int i = 0; i < 8; i++) begin
      mode(1'b1, 1'b1, src_t[i], edg_t[i]);
      clear_count;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      tick(200);
      #1 check(pulse_count, exp_t[i]);
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      {pulse_pin_enable, output_mask, polarity_select, port_data} <= out_t[i][4:1];
      tick(2);
      #1 check(pulse_pin, out_t[i][0]);
    end
    wrap_up();
  end
endmodule
bind pwm_one_shot_timer pwm_timer_sva #(.CNT_WIDTH(CNT_WIDTH)) chk (.sys_clk, .resetn,
  .ce, .trigger_source_selector, .software_trigger_bits, .timer_run_enable,
  .operation_mode_select, .count_clock_select, .output_mask, .trigger_edge_select,
  .irq_enable, .irq_cause_select, .irq_flag_write0, .dma_clear, .pulse_pin_enable,
  .polarity_select, .port_data, .timer_value, .running, .irq_flag, .irq, .pulse_pin);
